//--- src/swo_pkg.sv
// Constants, encodings and register map of the switch output block
// How it works
// - Diagnostic mode reacts only to the chosen event class: alarm, warning, or either.
// - Diagnostic mode keeps the output closed and opens it while an event of that class is present.
// - Function off holds the output open and function on holds it closed.
// - Digital output mode makes the output follow the selected discrete diagnostic block.
// - With switch-on above switch-off, the output closes when the value exceeds switch-on.
// - With switch-on above switch-off, the output opens when the value drops below switch-off.
// - With switch-on below switch-off, the output closes when the value drops below switch-on.
// - With switch-on below switch-off, the output opens when the value rises above switch-off.
// - In limit mode with a variable assigned, closing waits a switch-on delay of 0 to 100 s in tenths.
// - In limit mode with a variable assigned, opening waits a separate switch-off delay of 0 to 100 s.
// - In limit or digital output mode an error forces the chosen failure state: actual, open or closed.
// - The present switch state is readable as status.
// - Inversion swaps open and closed; without it the state passes unchanged.
package swo_pkg;

	// ==========================================================
	// Bus and data widths
	localparam int ADDR_W = 8;
	localparam int DATA_W = 32;
	localparam int DLY_W  = 10;

	// ==========================================================
	// Register offsets (byte addresses)
	localparam logic [ADDR_W-1:0] CTRL_OFFS      = 8'h00;
	localparam logic [ADDR_W-1:0] ON_VALUE_OFFS  = 8'h04;
	localparam logic [ADDR_W-1:0] OFF_VALUE_OFFS = 8'h08;
	localparam logic [ADDR_W-1:0] ON_DELAY_OFFS  = 8'h0c;
	localparam logic [ADDR_W-1:0] OFF_DELAY_OFFS = 8'h10;
	localparam logic [ADDR_W-1:0] STATUS_OFFS    = 8'h14;

	// ==========================================================
	// Control register field positions
	localparam int CTRL_FUNC_LSB  = 0;
	localparam int CTRL_CLASS_LSB = 4;
	localparam int CTRL_FAIL_LSB  = 8;
	localparam int CTRL_INV_BIT   = 12;
	localparam int CTRL_LIMEN_BIT = 16;
	localparam int CTRL_SEL_LSB   = 17;

	// Status register bit positions
	localparam int STAT_OUT_BIT   = 0;
	localparam int STAT_BASE_BIT  = 1;
	localparam int STAT_ERR_BIT   = 2;
	localparam int STAT_PEND_ON   = 3;
	localparam int STAT_PEND_OFF  = 4;
	localparam int STAT_LIMIT_BIT = 5;

	// ==========================================================
	// Encodings
	localparam logic [2:0] FUNC_OFF     = 3'h0;
	localparam logic [2:0] FUNC_ON      = 3'h1;
	localparam logic [2:0] FUNC_DIAG    = 3'h2;
	localparam logic [2:0] FUNC_LIMIT   = 3'h3;
	localparam logic [2:0] FUNC_DIGITAL = 3'h4;

	localparam logic [1:0] CLASS_ALARM  = 2'h0;
	localparam logic [1:0] CLASS_WARN   = 2'h1;
	localparam logic [1:0] CLASS_EITHER = 2'h2;

	localparam logic [1:0] FAIL_ACTUAL  = 2'h0;
	localparam logic [1:0] FAIL_OPEN    = 2'h1;
	localparam logic [1:0] FAIL_CLOSED  = 2'h2;

	localparam logic [1:0] SEL_OFF      = 2'h0;
	localparam logic [1:0] SEL_AD1      = 2'h1;
	localparam logic [1:0] SEL_AD2      = 2'h2;

	// ==========================================================
	// Reset values
	localparam logic [DATA_W-1:0] CTRL_RESET  = 32'h0000_0000;
	localparam logic [DATA_W-1:0] VALUE_RESET = 32'h0000_0000;
	localparam logic [DLY_W-1:0]  DELAY_RESET = 10'h000;

	// ==========================================================
	// Timing: delays counted in tenths of a second
	localparam int CLK_PERIOD_NS = 25;
	localparam int TENTH_NS      = 100_000_000;
	localparam int TENTH_CYCLES  = TENTH_NS / CLK_PERIOD_NS;
	localparam logic [DLY_W-1:0] DELAY_MAX = 10'h3e8;

endpackage

//--- src/swo_delay_timer.sv
// Restartable delay timer counting tenths of a second
`timescale 1ns/100ps
module swo_delay_timer
	import swo_pkg::*;
#(
	parameter int TICK_CYCLES = swo_pkg::TENTH_CYCLES
)
(
	// Clock and reset
	input  wire logic                    ref_clk,
	input  wire logic                    rst_n,
	// Control
	input  wire logic                    run,
	input  wire logic [swo_pkg::DLY_W-1:0] delayTenths,
	// Result
	output logic                         done,
	output logic                         pending
);
	import swo_pkg::*;

	typedef struct packed {
		logic [31:0]      prescale;
		logic [DLY_W-1:0] tenths;
	} swo_tmr_t;

	swo_tmr_t st_reg;
	swo_tmr_t st_next;

	// ==========================================================
	// Counting
	always_comb
	begin
		st_next = st_reg;
		if (!run)
		begin
			st_next.prescale = 32'h0;
			st_next.tenths   = '0;
		end
		else if (st_reg.tenths < delayTenths)
		begin
			if (st_reg.prescale >= 32'(TICK_CYCLES - 1))
			begin
				st_next.prescale = 32'h0;
				st_next.tenths   = st_reg.tenths + 10'h001;
			end
			else
				st_next.prescale = st_reg.prescale + 32'h1;
		end
	end

	always_ff @(posedge ref_clk or negedge rst_n)
	begin
		if (!rst_n)
			st_reg <= '0;
		else
			st_reg <= st_next;
	end

	// Prescaler restarts with each run, so the delay is exact, not one tick short
	assign done    = run && (st_reg.tenths >= delayTenths);
	assign pending = run && !done;

endmodule

//--- src/swo_switch_output.sv
// Switch output controller with limit comparator, delays and register port
//
// Added by the designer: the register addresses and strobed register access.
`timescale 1ns/100ps
module swo_switch_output
	import swo_pkg::*;
#(
	parameter int TICK_CYCLES = swo_pkg::TENTH_CYCLES
)
(
	// Clock and reset
	input  wire logic                       ref_clk,
	input  wire logic                       rst_n,
	// Register port
	input  wire logic [swo_pkg::ADDR_W-1:0] regAddr,
	input  wire logic [swo_pkg::DATA_W-1:0] regWdata,
	input  wire logic                       regWr,
	input  wire logic                       regRd,
	output logic      [swo_pkg::DATA_W-1:0] regRdata,
	// Measurement and diagnostics
	input  wire logic [swo_pkg::DATA_W-1:0] procValue,
	input  wire logic                       diagAlarm,
	input  wire logic                       diagWarning,
	input  wire logic                       deviceError,
	input  wire logic                       discreteOut1,
	input  wire logic                       discreteOut2,
	// Switch output, high means closed (conductive)
	output logic                            switchClosed
);
	import swo_pkg::*;

	typedef struct packed {
		logic [2:0]        func;
		logic [1:0]        diagClass;
		logic [1:0]        failMode;
		logic              invert;
		logic              limitEn;
		logic [1:0]        statusSel;
		logic [DATA_W-1:0] onValue;
		logic [DATA_W-1:0] offValue;
		logic [DLY_W-1:0]  onDelay;
		logic [DLY_W-1:0]  offDelay;
		logic              limitClosed;
		logic              outClosed;
		logic              baseClosed;
		logic [DATA_W-1:0] rdata;
	} swo_state_t;

	swo_state_t st_reg;
	swo_state_t st_next;

	logic signed [DATA_W-1:0] pvS;
	logic signed [DATA_W-1:0] onS;
	logic signed [DATA_W-1:0] offS;
	logic onAboveOff;
	logic closeCond;
	logic openCond;
	logic onRun;
	logic offRun;
	logic onDone;
	logic offDone;
	logic onPend;
	logic offPend;
	logic diagEvent;
	logic digitalState;
	logic baseState;
	logic failState;
	logic limitActive;

	// ==========================================================
	// Limit comparator
	assign pvS  = procValue;
	assign onS  = st_reg.onValue;
	assign offS = st_reg.offValue;
	// Equal thresholds fall in the first case; the window is empty so state still holds
	assign onAboveOff = onS >= offS;

	always_comb
	begin
		if (onAboveOff)
		begin
			closeCond = pvS > onS;
			openCond  = pvS < offS;
		end
		else
		begin
			closeCond = pvS < onS;
			openCond  = pvS > offS;
		end
	end

	assign limitActive = (st_reg.func == FUNC_LIMIT) && st_reg.limitEn;

	// Hysteresis: a timer runs only toward the opposite state
	// Condition loss stops the run and clears the timer
	assign onRun  = limitActive && !st_reg.limitClosed && closeCond;
	assign offRun = limitActive && st_reg.limitClosed && openCond;

	// ==========================================================
	// Delay timers
	// Switch-on delay
	swo_delay_timer #(
		.TICK_CYCLES (TICK_CYCLES)
	) onTimer (
		.ref_clk     (ref_clk),
		.rst_n       (rst_n),
		.run         (onRun),
		.delayTenths (st_reg.onDelay),
		.done        (onDone),
		.pending     (onPend)
	);

	swo_delay_timer #(
		.TICK_CYCLES (TICK_CYCLES)
	) offTimer (
		.ref_clk     (ref_clk),
		.rst_n       (rst_n),
		.run         (offRun),
		.delayTenths (st_reg.offDelay),
		.done        (offDone),
		.pending     (offPend)
	);

	// ==========================================================
	// Diagnostic and digital sources
	always_comb
	begin
		unique case (st_reg.diagClass)
			CLASS_ALARM:  diagEvent = diagAlarm;
			CLASS_WARN:   diagEvent = diagWarning;
			CLASS_EITHER: diagEvent = diagAlarm | diagWarning;
			default:      diagEvent = diagAlarm;
		endcase
	end

	always_comb
	begin
		unique case (st_reg.statusSel)
			SEL_AD1: digitalState = discreteOut1;
			SEL_AD2: digitalState = discreteOut2;
			default: digitalState = 1'b0;
		endcase
	end

	// ==========================================================
	// Function selection
	always_comb
	begin
		unique case (st_reg.func)
			FUNC_OFF:     baseState = 1'b0;
			FUNC_ON:      baseState = 1'b1;
			FUNC_DIAG:    baseState = !diagEvent;
			FUNC_LIMIT:   baseState = st_reg.limitClosed;
			FUNC_DIGITAL: baseState = digitalState;
			default:      baseState = 1'b0;
		endcase
	end

	always_comb
	begin
		failState = baseState;
		if (deviceError && (st_reg.func == FUNC_LIMIT || st_reg.func == FUNC_DIGITAL))
		begin
			unique case (st_reg.failMode)
				FAIL_OPEN:   failState = 1'b0;
				FAIL_CLOSED: failState = 1'b1;
				default:     failState = baseState;
			endcase
		end
	end

	// ==========================================================
	// Register writes and state update
	always_comb
	begin
		st_next = st_reg;

		// Limit state: normally closed when no variable is assigned
		if (!limitActive)
			st_next.limitClosed = 1'b1;
		else if (onDone)
			st_next.limitClosed = 1'b1;
		else if (offDone)
			st_next.limitClosed = 1'b0;

		st_next.baseClosed = failState;
		st_next.outClosed  = failState ^ st_reg.invert;

		if (regWr)
		begin
			unique case (regAddr)
				CTRL_OFFS:
				begin
					// Unknown function codes fall back to open
					if (regWdata[CTRL_FUNC_LSB +: 3] > FUNC_DIGITAL)
						st_next.func = FUNC_OFF;
					else
						st_next.func = regWdata[CTRL_FUNC_LSB +: 3];
					st_next.diagClass = regWdata[CTRL_CLASS_LSB +: 2];
					st_next.failMode  = regWdata[CTRL_FAIL_LSB +: 2];
					st_next.invert    = regWdata[CTRL_INV_BIT];
					st_next.limitEn   = regWdata[CTRL_LIMEN_BIT];
					st_next.statusSel = regWdata[CTRL_SEL_LSB +: 2];
				end
				ON_VALUE_OFFS:  st_next.onValue  = regWdata;
				OFF_VALUE_OFFS: st_next.offValue = regWdata;
				// Delays above 100 s are clamped rather than wrapped
				ON_DELAY_OFFS:
				begin
					if (regWdata[DLY_W-1:0] > DELAY_MAX || regWdata[DATA_W-1:DLY_W] != '0)
						st_next.onDelay = DELAY_MAX;
					else
						st_next.onDelay = regWdata[DLY_W-1:0];
				end
				OFF_DELAY_OFFS:
				begin
					if (regWdata[DLY_W-1:0] > DELAY_MAX || regWdata[DATA_W-1:DLY_W] != '0)
						st_next.offDelay = DELAY_MAX;
					else
						st_next.offDelay = regWdata[DLY_W-1:0];
				end
				default:
				begin
				end
			endcase
		end

		// Read data stands only in the cycle after the strobe
		st_next.rdata = '0;
		if (regRd)
		begin
			unique case (regAddr)
				CTRL_OFFS:
				begin
					st_next.rdata[CTRL_FUNC_LSB +: 3]  = st_reg.func;
					st_next.rdata[CTRL_CLASS_LSB +: 2] = st_reg.diagClass;
					st_next.rdata[CTRL_FAIL_LSB +: 2]  = st_reg.failMode;
					st_next.rdata[CTRL_INV_BIT]        = st_reg.invert;
					st_next.rdata[CTRL_LIMEN_BIT]      = st_reg.limitEn;
					st_next.rdata[CTRL_SEL_LSB +: 2]   = st_reg.statusSel;
				end
				ON_VALUE_OFFS:  st_next.rdata = st_reg.onValue;
				OFF_VALUE_OFFS: st_next.rdata = st_reg.offValue;
				ON_DELAY_OFFS:  st_next.rdata[DLY_W-1:0] = st_reg.onDelay;
				OFF_DELAY_OFFS: st_next.rdata[DLY_W-1:0] = st_reg.offDelay;
				STATUS_OFFS:
				begin
					st_next.rdata[STAT_OUT_BIT]   = st_reg.outClosed;
					st_next.rdata[STAT_BASE_BIT]  = st_reg.baseClosed;
					st_next.rdata[STAT_ERR_BIT]   = deviceError;
					st_next.rdata[STAT_PEND_ON]   = onPend;
					st_next.rdata[STAT_PEND_OFF]  = offPend;
					st_next.rdata[STAT_LIMIT_BIT] = st_reg.limitClosed;
				end
				default:        st_next.rdata = '0;
			endcase
		end
	end

	always_ff @(posedge ref_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			st_reg             <= '0;
			st_reg.func        <= CTRL_RESET[CTRL_FUNC_LSB +: 3];
			st_reg.onValue     <= VALUE_RESET;
			st_reg.offValue    <= VALUE_RESET;
			st_reg.onDelay     <= DELAY_RESET;
			st_reg.offDelay    <= DELAY_RESET;
			st_reg.limitClosed <= 1'b1;
		end
		else
			st_reg <= st_next;
	end

	// ==========================================================
	// Outputs
	assign regRdata     = st_reg.rdata;
	assign switchClosed = st_reg.outClosed;

endmodule

//--- bench/swo_switch_output_properties.sv
// Port-level assertions for the switch output block
`timescale 1ns/100ps
module swo_switch_output_properties
	import swo_pkg::*;
(
	// Clock and reset
	input wire logic                       ref_clk,
	input wire logic                       rst_n,
	// Register port
	input wire logic [swo_pkg::ADDR_W-1:0] regAddr,
	input wire logic [swo_pkg::DATA_W-1:0] regWdata,
	input wire logic                       regWr,
	input wire logic                       regRd,
	input wire logic [swo_pkg::DATA_W-1:0] regRdata,
	// Inputs and switch
	input wire logic [swo_pkg::DATA_W-1:0] procValue,
	input wire logic                       diagAlarm,
	input wire logic                       diagWarning,
	input wire logic                       deviceError,
	input wire logic                       discreteOut1,
	input wire logic                       discreteOut2,
	input wire logic                       switchClosed
);
	// ======
	// Shadow of the control register and the switch-on value
	logic [DATA_W-1:0] ctrl_reg;
	logic [DATA_W-1:0] onValue_reg;
	logic [2:0]        funcSel;
	logic [1:0]        classSel;
	logic [1:0]        failSel;
	logic [1:0]        srcSel;
	logic              invSel;
	logic              diagEvent;
	logic              digState;

	always_ff @(posedge ref_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			ctrl_reg    <= CTRL_RESET;
			onValue_reg <= VALUE_RESET;
		end
		else if (regWr && regAddr == CTRL_OFFS)
			ctrl_reg <= regWdata;
		else if (regWr && regAddr == ON_VALUE_OFFS)
			onValue_reg <= regWdata;
	end

	assign funcSel   = ctrl_reg[CTRL_FUNC_LSB +: 3];
	assign classSel  = ctrl_reg[CTRL_CLASS_LSB +: 2];
	assign failSel   = ctrl_reg[CTRL_FAIL_LSB +: 2];
	assign srcSel    = ctrl_reg[CTRL_SEL_LSB +: 2];
	assign invSel    = ctrl_reg[CTRL_INV_BIT];
	assign diagEvent = (classSel == CLASS_WARN) ? diagWarning
		: (classSel == CLASS_EITHER) ? (diagAlarm | diagWarning) : diagAlarm;
	// Open and closed failure codes differ in both bits; bit 1 set means closed
	assign digState  = (deviceError && ^failSel) ? failSel[1]
		: (srcSel == SEL_AD1) ? discreteOut1 : (srcSel == SEL_AD2) ? discreteOut2 : 1'b0;

	// ======
	// Assertions
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (!rst_n);

	chk_read_idle: assert property (!$past(regRd) |-> regRdata == '0)
		else $error("read data not zero outside a read answer");
	chk_status_bit: assert property (regRd && regAddr == STATUS_OFFS |=> regRdata[0] == $past(switchClosed))
		else $error("status bit does not match switch output");
	chk_unmapped_zero: assert property (regRd && regAddr > STATUS_OFFS |=> regRdata == '0)
		else $error("unmapped read not zero");
	chk_value_readback: assert property (regRd && regAddr == ON_VALUE_OFFS |=> regRdata == $past(onValue_reg))
		else $error("switch-on value readback wrong");
	chk_fixed_state: assert property (regWr && regAddr == CTRL_OFFS && regWdata[2:1] == 2'h0 |-> ##2
		switchClosed == ($past(regWdata[0], 2) ^ $past(regWdata[CTRL_INV_BIT], 2)))
		else $error("fixed function state wrong");
	chk_diag_class: assert property ($past(funcSel) == FUNC_DIAG |->
		switchClosed == (!$past(diagEvent) ^ $past(invSel)))
		else $error("diagnostic mode state wrong");
	chk_digital_follow: assert property ($past(funcSel) == FUNC_DIGITAL |->
		switchClosed == ($past(digState) ^ $past(invSel)))
		else $error("digital mode state wrong");
	chk_limit_fail: assert property ($past(funcSel) == FUNC_LIMIT && $past(deviceError) && $past(^failSel) |->
		switchClosed == ($past(failSel[1]) ^ $past(invSel)))
		else $error("limit failure state wrong");
endmodule

//--- bench/swo_contact_load.sv
// Load wired in series with the switch contact
`timescale 1ns/100ps
module swo_contact_load
(
	// Contact
	input  wire logic switchClosed,
	// Load state
	output logic      loadPowered
);
	// A closed contact carries current; no bounce is modelled
	assign loadPowered = switchClosed;
endmodule

//--- bench/swo_switch_output_tb.sv
// Register-driven testbench of the switch output block
`timescale 1ns/100ps
module swo_switch_output_tb;
	import swo_pkg::*;
	logic              ref_clk;
	logic              rst_n;
	logic [ADDR_W-1:0] regAddr;
	logic [DATA_W-1:0] regWdata;
	logic              regWr;
	logic              regRd;
	logic [DATA_W-1:0] regRdata;
	logic [DATA_W-1:0] procValue;
	logic              diagAlarm;
	logic              diagWarning;
	logic              deviceError;
	logic              discreteOut1;
	logic              discreteOut2;
	logic              switchClosed;
	logic              loadPowered;
	logic [31:0]       v;
	int                err_count;
	int                num_checks;
	int                cycleCount;

	// Short tenth so the delays stay a few cycles long
	swo_switch_output #(.TICK_CYCLES(4)) swo_switch_output_inst (.ref_clk(ref_clk), .rst_n(rst_n),
		.regAddr(regAddr), .regWdata(regWdata), .regWr(regWr), .regRd(regRd), .regRdata(regRdata),
		.procValue(procValue), .diagAlarm(diagAlarm), .diagWarning(diagWarning), .deviceError(deviceError),
		.discreteOut1(discreteOut1), .discreteOut2(discreteOut2), .switchClosed(switchClosed));
	swo_contact_load swo_contact_load_inst (.switchClosed(switchClosed), .loadPowered(loadPowered));

	always #12.5 ref_clk = ~ref_clk;

	// ======
	// Tasks
	task automatic cmpW(input string n, input logic [31:0] e, input logic [31:0] g);
		num_checks++;
		if (g !== e)
		begin
			err_count++;
			$display("BAD %s expected %h seen %h", n, e, g);
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge ref_clk);
		regAddr  <= a;
		regWdata <= d;
		regWr    <= 1'b1;
		@(posedge ref_clk);
		regWr <= 1'b0;
	endtask
	task automatic rd(input logic [7:0] a, output logic [31:0] d);
		@(posedge ref_clk);
		regAddr <= a;
		regRd   <= 1'b1;
		@(posedge ref_clk);
		regRd <= 1'b0;
		#1;
		d = regRdata;
	endtask
	task automatic sw(input int n, input logic e);
		logic [31:0] s;
		repeat (n) @(posedge ref_clk);
		#1;
		cmpW("load", 32'(e), 32'(loadPowered));
		rd(STATUS_OFFS, s);
		cmpW("status", 32'(e), 32'(s[STAT_OUT_BIT]));
	endtask
	task automatic pv(input logic [31:0] x);
		@(posedge ref_clk);
		procValue <= x;
	endtask
	function automatic logic [31:0] ctl(input logic [2:0] f, input logic [1:0] c, input logic [1:0] fl,
		input logic i, input logic l, input logic [1:0] s);
		return 32'(f) << CTRL_FUNC_LSB | 32'(c) << CTRL_CLASS_LSB | 32'(fl) << CTRL_FAIL_LSB
			| 32'(i) << CTRL_INV_BIT | 32'(l) << CTRL_LIMEN_BIT | 32'(s) << CTRL_SEL_LSB;
	endfunction
	task automatic dg(input logic [1:0] s, input logic [1:0] f, input logic [2:0] in, input logic e);
		wr(CTRL_OFFS, ctl(FUNC_DIGITAL, 2'h0, f, 1'b0, 1'b0, s));
		{discreteOut1, discreteOut2, deviceError} <= in;
		sw(3, e);
	endtask
	task automatic end_of_test();
		$display("checks %0d errors %0d", num_checks, err_count);
		if (err_count == 0 && num_checks > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask

	// Whole run needs well under a thousand cycles
	always @(posedge ref_clk)
	begin
		cycleCount++;
		if (cycleCount == 5000)
		begin
			err_count++;
			end_of_test();
		end
	end

	// ======
	// Sequence
	initial
	begin
		{ref_clk, rst_n, regWr, regRd, diagAlarm, diagWarning, deviceError, discreteOut1, discreteOut2} = '0;
		{regAddr, regWdata, procValue} = '0;
		repeat (6) @(posedge ref_clk);
		rst_n <= 1'b1;
		rd(CTRL_OFFS, v);
		cmpW("ctrl", CTRL_RESET, v);
		rd(ON_DELAY_OFFS, v);
		cmpW("on delay", 32'(DELAY_RESET), v);
		sw(1, 1'b0);
		for (int k = 0; k < 4; k++)
		begin
			wr(CTRL_OFFS, ctl(3'(k[0]), 2'h0, 2'h0, k[1], 1'b0, 2'h0));
			sw(3, k[0] ^ k[1]);
		end
		for (int c = 0; c < 3; c++)
		begin
			wr(CTRL_OFFS, ctl(FUNC_DIAG, 2'(c), 2'h0, 1'b0, 1'b0, 2'h0));
			for (int k = 0; k < 4; k++)
			begin
				@(posedge ref_clk);
				{diagAlarm, diagWarning} <= 2'(k);
				sw(3, !((c != 1 && k[1]) || (c != 0 && k[0])));
			end
		end
		dg(SEL_AD1, FAIL_OPEN, 3'b100, 1'b1);
		dg(SEL_AD1, FAIL_OPEN, 3'b010, 1'b0);
		dg(SEL_AD2, FAIL_OPEN, 3'b010, 1'b1);
		dg(SEL_AD2, FAIL_OPEN, 3'b011, 1'b0);
		dg(SEL_AD2, FAIL_ACTUAL, 3'b011, 1'b1);
		dg(SEL_AD1, FAIL_CLOSED, 3'b001, 1'b1);
		dg(SEL_OFF, FAIL_OPEN, 3'b110, 1'b0);
		wr(ON_DELAY_OFFS, 32'h0000_03ff);
		rd(ON_DELAY_OFFS, v);
		cmpW("on delay clamp", 32'(DELAY_MAX), v);
		wr(8'h18, 32'hffff_ffff);
		rd(8'h18, v);
		cmpW("unmapped", 32'h0, v);
		// Unknown function code falls back to off, so the switch opens
		wr(CTRL_OFFS, ctl(3'h7, 2'h0, 2'h0, 1'b0, 1'b0, 2'h0));
		rd(CTRL_OFFS, v);
		cmpW("func clamp", 32'h0, v);
		sw(3, 1'b0);
		wr(ON_VALUE_OFFS, 32'h0000_0064);
		wr(OFF_VALUE_OFFS, 32'h0000_0032);
		wr(ON_DELAY_OFFS, 32'h0000_0002);
		wr(OFF_DELAY_OFFS, 32'h0000_0000);
		pv(32'h0000_003c);
		wr(CTRL_OFFS, ctl(FUNC_LIMIT, 2'h0, FAIL_CLOSED, 1'b0, 1'b1, 2'h0));
		sw(3, 1'b1);
		pv(32'h0000_0028);
		sw(3, 1'b0);
		pv(32'h0000_004b);
		sw(3, 1'b0);
		pv(32'h0000_0065);
		repeat (4) @(posedge ref_clk);
		pv(32'h0000_004b);
		pv(32'h0000_0065);
		sw(6, 1'b0);
		sw(4, 1'b1);
		wr(OFF_DELAY_OFFS, 32'h0000_0003);
		pv(32'h0000_0028);
		sw(9, 1'b1);
		sw(6, 1'b0);
		@(posedge ref_clk);
		deviceError <= 1'b1;
		sw(3, 1'b1);
		@(posedge ref_clk);
		deviceError <= 1'b0;
		sw(3, 1'b0);
		wr(OFF_DELAY_OFFS, 32'h0000_0000);
		wr(ON_DELAY_OFFS, 32'h0000_0000);
		wr(ON_VALUE_OFFS, 32'hffff_fffb);
		wr(OFF_VALUE_OFFS, 32'h0000_0064);
		rd(ON_VALUE_OFFS, v);
		cmpW("on value", 32'hffff_fffb, v);
		sw(3, 1'b0);
		pv(32'hffff_fff6);
		sw(3, 1'b1);
		pv(32'h0000_004b);
		sw(3, 1'b1);
		pv(32'h0000_0065);
		sw(3, 1'b0);
		end_of_test();
	end
endmodule

bind swo_switch_output swo_switch_output_properties swo_switch_output_properties_inst (.ref_clk(ref_clk),
	.rst_n(rst_n), .regAddr(regAddr), .regWdata(regWdata), .regWr(regWr), .regRd(regRd), .regRdata(regRdata),
	.procValue(procValue), .diagAlarm(diagAlarm), .diagWarning(diagWarning), .deviceError(deviceError),
	.discreteOut1(discreteOut1), .discreteOut2(discreteOut2), .switchClosed(switchClosed));
